// ### design/plcfg_pkg.sv
// Purpose: Shared constants and types of the configurable logic fabric.
// Assumes: One 250 MHz core clock; registers reached over APB.
// Notes:   Every register takes one aligned 32-bit word.

`default_nettype none

package plcfg_pkg;

	// ------------------------------------------------------------
	// Fabric geometry
	// ------------------------------------------------------------
	localparam int N_BLK   = 8;
	localparam int N_MC    = 4;
	localparam int N_IN    = 18;
	localparam int N_PIN   = 32;
	localparam int N_DED   = 2;
	localparam int N_CKPIN = 3;
	localparam int N_MCALL = N_BLK * N_MC;
	localparam int GRP_W   = N_MCALL + N_PIN + N_DED;
	localparam int SEL_W   = 7;
	localparam int SEL_CNT = N_BLK * N_IN;
	localparam int ADDR_W  = 12;

	// Global routing pool bit positions.
	localparam int GRP_FB_LSB  = 0;
	localparam int GRP_PIN_LSB = N_MCALL;
	localparam int GRP_DED_LSB = N_MCALL + N_PIN;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] SEL_BASE  = 12'h000;
	localparam logic [11:0] SEL_END   = 12'h240;
	localparam logic [11:0] MASK_BASE = 12'h400;
	localparam logic [11:0] MASK_END  = 12'h480;
	localparam logic [11:0] INV_BASE  = 12'h500;
	localparam logic [11:0] INV_END   = 12'h580;
	localparam logic [11:0] MCC_BASE  = 12'h600;
	localparam logic [11:0] MCC_END   = 12'h680;
	localparam logic [11:0] CKS_BASE  = 12'h700;
	localparam logic [11:0] CKS_END   = 12'h720;
	localparam logic [11:0] CKM_END   = 12'h740;
	localparam logic [11:0] CKI_END   = 12'h760;
	localparam logic [11:0] IOC_BASE  = 12'h800;
	localparam logic [11:0] IOC_END   = 12'h880;
	localparam logic [11:0] ST_MC     = 12'hA00;
	localparam logic [11:0] ST_PIN    = 12'hA04;
	localparam logic [11:0] ST_DRV    = 12'hA08;

	// ------------------------------------------------------------
	// Field layouts and reset values
	// ------------------------------------------------------------
	localparam int MCC_REG_BIT   = 0;
	localparam int MCC_XOR_BIT   = 1;
	localparam int IOC_W         = 14;
	localparam int IOC_SRC_LSB   = 0;
	localparam int IOC_MODE_LSB  = 5;
	localparam int IOC_OE_LSB    = 7;
	localparam int IOC_TOTEM_BIT = 12;
	localparam int IOC_SLOW_BIT  = 13;

	localparam logic [6:0]  SEL_RST  = 7'h00;
	localparam logic [17:0] TERM_RST = 18'h0_0000;
	localparam logic [1:0]  MCC_RST  = 2'h0;
	localparam logic [1:0]  CKS_RST  = 2'h0;
	localparam logic [13:0] IOC_RST  = 14'h1000;

	// Clock source select code of the local product-term clock.
	localparam logic [1:0] CKS_TERM = 2'h3;

	// I/O cell direction modes; the fourth code acts as input.
	typedef enum logic [1:0] {
		IO_INPUT,
		IO_OUTPUT,
		IO_BIDIR
	} plcfg_io_mode_t;

endpackage

`default_nettype wire

// ### design/plcfg_blk_if.sv
// Purpose: Carries one logic block's routing inputs and configuration.
// Assumes: Driven by the fabric top, read by one logic block.
// Notes:   The routing pool copy is the same for every block.

`timescale 1ns/1ns
`default_nettype none

interface plcfg_blk_if;
	logic [plcfg_pkg::GRP_W-1:0]                      global_routing_pool;
	logic [plcfg_pkg::N_IN-1:0][plcfg_pkg::SEL_W-1:0] in_sel;
	logic [plcfg_pkg::N_MC-1:0][plcfg_pkg::N_IN-1:0]  pt_mask;
	logic [plcfg_pkg::N_MC-1:0][plcfg_pkg::N_IN-1:0]  pt_inv;
	logic [plcfg_pkg::N_MC-1:0]                       mc_reg;
	logic [plcfg_pkg::N_MC-1:0]                       mc_xor;
	logic [1:0]                                       clk_sel;
	logic [plcfg_pkg::N_IN-1:0]                       clk_mask;
	logic [plcfg_pkg::N_IN-1:0]                       clk_inv;
	logic [plcfg_pkg::N_CKPIN-1:0]                    pin_rise;
	logic [plcfg_pkg::N_MC-1:0]                       mc_out;

	modport blk (
		input  global_routing_pool, in_sel, pt_mask, pt_inv, mc_reg, mc_xor,
		input  clk_sel, clk_mask, clk_inv, pin_rise,
		output mc_out
	);
	modport fab (
		output global_routing_pool, in_sel, pt_mask, pt_inv, mc_reg, mc_xor,
		output clk_sel, clk_mask, clk_inv, pin_rise,
		input  mc_out
	);
endinterface

`default_nettype wire

// ### design/plcfg_logic_block.sv
// Purpose: One logic block of four macrocells with its own clock choice.
// Assumes: Clock sources arrive as one-cycle rise pulses on core_clk.
// Notes:   Each macrocell term is one AND of chosen true or inverted inputs.

`timescale 1ns/1ns
`default_nettype none

module plcfg_logic_block (
	input  wire logic core_clk, // Core clock.
	input  wire logic rst_n,    // Synchronous reset, active low.
	plcfg_blk_if.blk  bus       // Routing inputs and configuration.
);

	logic [plcfg_pkg::N_IN-1:0] blk_in;
	logic [plcfg_pkg::N_MC-1:0] term;
	logic [plcfg_pkg::N_MC-1:0] comb_out;
	logic [plcfg_pkg::N_MC-1:0] mc_reg_ff;
	logic                       clk_term;
	logic                       clk_term_ff;
	logic                       clk_term_rise;
	logic                       clk_en;

	// ------------------------------------------------------------
	// Input selection
	// ------------------------------------------------------------
	// Each of the eighteen inputs picks one pool signal; codes past the pool read low.
	genvar gi;
	generate
		for (gi = 0; gi < plcfg_pkg::N_IN; gi++) begin : g_in
			assign blk_in[gi] = (int'(bus.in_sel[gi]) < plcfg_pkg::GRP_W) ?
			                    bus.global_routing_pool[bus.in_sel[gi]] : 1'b0;
		end
	endgenerate

	// ------------------------------------------------------------
	// Macrocell terms and output choice
	// ------------------------------------------------------------
	// An unmasked input is ignored; an empty mask gives a constant high term.
	genvar gm;
	generate
		for (gm = 0; gm < plcfg_pkg::N_MC; gm++) begin : g_mc
			assign term[gm]       = &((blk_in ^ bus.pt_inv[gm]) | ~bus.pt_mask[gm]);
			assign comb_out[gm]   = term[gm] ^ bus.mc_xor[gm];
			assign bus.mc_out[gm] = bus.mc_reg[gm] ? mc_reg_ff[gm] : comb_out[gm];
		end
	endgenerate

	// ------------------------------------------------------------
	// Block clock selection
	// ------------------------------------------------------------
	// The product-term clock is built from this block's own inputs only.
	// local term clock
	assign clk_term      = &((blk_in ^ bus.clk_inv) | ~bus.clk_mask);
	assign clk_term_rise = clk_term & ~clk_term_ff;
	assign clk_en = (bus.clk_sel == plcfg_pkg::CKS_TERM) ? clk_term_rise :
	                bus.pin_rise[bus.clk_sel];

	// Remembers the term level to find its rising edge.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			clk_term_ff <= 1'b0;
		end else begin
			clk_term_ff <= clk_term;
		end
	end

	// Macrocell flip-flops load only on the chosen clock edge.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			mc_reg_ff <= '0;
		end else if (clk_en) begin
			mc_reg_ff <= comb_out;
		end
	end

endmodule

`default_nettype wire

// ### design/plcfg_top.sv
// Purpose: Configurable fabric of eight logic blocks and thirty-two I/O cells.
// Assumes: APB master on core_clk; pins and clock pins are asynchronous.
// Notes:   Configuration lives in flip-flops written over APB.
//
// Implementation choices: the APB slave port and the register offsets.

`timescale 1ns/1ns
`default_nettype none

module plcfg_top (
	input  wire logic        core_clk,    // Core clock, 250 MHz.
	input  wire logic        rst_n,       // Synchronous reset, active low.
	input  wire logic        psel,        // APB select.
	input  wire logic        penable,     // APB enable.
	input  wire logic        pwrite,      // APB write direction.
	input  wire logic [11:0] paddr,       // APB byte address.
	input  wire logic [31:0] pwdata,      // APB write data.
	output logic      [31:0] prdata,      // APB read data.
	output logic             pready,      // APB ready.
	output logic             pslverr,     // APB error on unmapped address.
	input  wire logic [31:0] io_in,       // Pin input levels.
	output logic      [31:0] io_out,      // Pin output levels.
	output logic      [31:0] io_drive_n,  // Pin drive enables, low drives.
	output logic      [31:0] io_slow,     // Pin slow edge-rate selects.
	input  wire logic [1:0]  ded_in,      // Dedicated input pins.
	input  wire logic        clock_pin_0, // Dedicated clock pin 0.
	input  wire logic        clock_pin_1, // Dedicated clock pin 1.
	input  wire logic        clock_pin_2  // Dedicated clock pin 2.
);

	// ------------------------------------------------------------
	// Configuration storage
	// ------------------------------------------------------------
	logic [plcfg_pkg::SEL_W-1:0] sel_ff  [0:plcfg_pkg::SEL_CNT-1];
	logic [plcfg_pkg::N_IN-1:0]  mask_ff [0:plcfg_pkg::N_MCALL-1];
	logic [plcfg_pkg::N_IN-1:0]  inv_ff  [0:plcfg_pkg::N_MCALL-1];
	logic [1:0]                  mcc_ff  [0:plcfg_pkg::N_MCALL-1];
	logic [1:0]                  cks_ff  [0:plcfg_pkg::N_BLK-1];
	logic [plcfg_pkg::N_IN-1:0]  ckm_ff  [0:plcfg_pkg::N_BLK-1];
	logic [plcfg_pkg::N_IN-1:0]  cki_ff  [0:plcfg_pkg::N_BLK-1];
	logic [plcfg_pkg::IOC_W-1:0] ioc_ff  [0:plcfg_pkg::N_PIN-1];

	logic [31:0] prdata_ff;
	logic        pslverr_ff;

	// Pin synchronisers and routing state.
	logic [31:0] pin_s1_ff;
	logic [31:0] pin_s2_ff;
	logic [1:0]  ded_s1_ff;
	logic [1:0]  ded_s2_ff;
	logic [2:0]  ck_s1_ff;
	logic [2:0]  ck_s2_ff;
	logic [2:0]  ck_s3_ff;
	logic [2:0]  ck_rise;
	logic [plcfg_pkg::N_MCALL-1:0] mc_out_all;
	logic [plcfg_pkg::N_MCALL-1:0] mc_fb_ff;
	logic [plcfg_pkg::GRP_W-1:0]   global_routing_pool;
	logic [31:0] io_out_ff;
	logic [31:0] io_drive_n_ff;
	logic [31:0] io_slow_ff;
	logic [31:0] nxt_io_out;
	logic [31:0] nxt_io_drive_n;
	logic [31:0] nxt_io_slow;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	// Range hits and word indices; every region base is aligned to its size.
	wire setup_ph = psel & ~penable;
	wire wr_acc   = psel & penable & pwrite;
	wire aligned  = (paddr[1:0] == 2'h0);
	wire hit_sel  = aligned && (paddr <  plcfg_pkg::SEL_END);
	wire hit_mask = aligned && (paddr >= plcfg_pkg::MASK_BASE) && (paddr < plcfg_pkg::MASK_END);
	wire hit_inv  = aligned && (paddr >= plcfg_pkg::INV_BASE) && (paddr < plcfg_pkg::INV_END);
	wire hit_mcc  = aligned && (paddr >= plcfg_pkg::MCC_BASE) && (paddr < plcfg_pkg::MCC_END);
	wire hit_cks  = aligned && (paddr >= plcfg_pkg::CKS_BASE) && (paddr < plcfg_pkg::CKS_END);
	wire hit_ckm  = aligned && (paddr >= plcfg_pkg::CKS_END) && (paddr < plcfg_pkg::CKM_END);
	wire hit_cki  = aligned && (paddr >= plcfg_pkg::CKM_END) && (paddr < plcfg_pkg::CKI_END);
	wire hit_ioc  = aligned && (paddr >= plcfg_pkg::IOC_BASE) && (paddr < plcfg_pkg::IOC_END);
	wire hit_stmc = (paddr == plcfg_pkg::ST_MC);
	wire hit_stpn = (paddr == plcfg_pkg::ST_PIN);
	wire hit_stdr = (paddr == plcfg_pkg::ST_DRV);
	wire hit_any  = hit_sel | hit_mask | hit_inv | hit_mcc | hit_cks | hit_ckm | hit_cki |
	                hit_ioc | hit_stmc | hit_stpn | hit_stdr;
	wire [7:0] sel_idx = paddr[9:2];
	wire [4:0] mc_idx  = paddr[6:2];
	wire [2:0] blk_idx = paddr[4:2];

	// Read word chosen during the setup phase; unmapped reads give zero.
	wire [31:0] rd_word =
		hit_sel  ? {25'h0, sel_ff[sel_idx]} :
		hit_mask ? {14'h0, mask_ff[mc_idx]} :
		hit_inv  ? {14'h0, inv_ff[mc_idx]} :
		hit_mcc  ? {30'h0, mcc_ff[mc_idx]} :
		hit_cks  ? {30'h0, cks_ff[blk_idx]} :
		hit_ckm  ? {14'h0, ckm_ff[blk_idx]} :
		hit_cki  ? {14'h0, cki_ff[blk_idx]} :
		hit_ioc  ? {18'h0, ioc_ff[mc_idx]} :
		hit_stmc ? mc_fb_ff :
		hit_stpn ? pin_s2_ff :
		hit_stdr ? ~io_drive_n_ff : 32'h0000_0000;

	// The access phase always completes in its first cycle.
	assign pready  = psel & penable;
	assign prdata  = prdata_ff;
	assign pslverr = pslverr_ff & pready;

	// Read data and error flag are captured at the setup edge.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else if (setup_ph) begin
			prdata_ff  <= pwrite ? 32'h0000_0000 : rd_word;
			pslverr_ff <= ~hit_any;
		end
	end

	// ------------------------------------------------------------
	// Configuration writes
	// ------------------------------------------------------------
	// Input selects of all blocks, eighteen words per block.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < plcfg_pkg::SEL_CNT; i++) sel_ff[i] <= plcfg_pkg::SEL_RST;
		end else if (wr_acc && hit_sel) begin
			sel_ff[sel_idx] <= pwdata[plcfg_pkg::SEL_W-1:0];
		end
	end

	// Macrocell term masks, inversions and output controls.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < plcfg_pkg::N_MCALL; i++) begin
				mask_ff[i] <= plcfg_pkg::TERM_RST;
				inv_ff[i]  <= plcfg_pkg::TERM_RST;
				mcc_ff[i]  <= plcfg_pkg::MCC_RST;
			end
		end else if (wr_acc) begin
			if (hit_mask) mask_ff[mc_idx] <= pwdata[plcfg_pkg::N_IN-1:0];
			if (hit_inv)  inv_ff[mc_idx]  <= pwdata[plcfg_pkg::N_IN-1:0];
			if (hit_mcc)  mcc_ff[mc_idx]  <= pwdata[1:0];
		end
	end

	// Block clock selects and product-term clock terms.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < plcfg_pkg::N_BLK; i++) begin
				cks_ff[i] <= plcfg_pkg::CKS_RST;
				ckm_ff[i] <= plcfg_pkg::TERM_RST;
				cki_ff[i] <= plcfg_pkg::TERM_RST;
			end
		end else if (wr_acc) begin
			if (hit_cks) cks_ff[blk_idx] <= pwdata[1:0];
			if (hit_ckm) ckm_ff[blk_idx] <= pwdata[plcfg_pkg::N_IN-1:0];
			if (hit_cki) cki_ff[blk_idx] <= pwdata[plcfg_pkg::N_IN-1:0];
		end
	end

	// I/O cell controls; reset leaves every driver totem-pole.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < plcfg_pkg::N_PIN; i++) ioc_ff[i] <= plcfg_pkg::IOC_RST;
		end else if (wr_acc && hit_ioc) begin
			ioc_ff[mc_idx] <= pwdata[plcfg_pkg::IOC_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// Pin synchronisers and clock pin edges
	// ------------------------------------------------------------
	// Two stages for every outside level; a third stage finds clock rises.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pin_s1_ff <= 32'h0000_0000;
			pin_s2_ff <= 32'h0000_0000;
			ded_s1_ff <= 2'h0;
			ded_s2_ff <= 2'h0;
			ck_s1_ff  <= 3'h0;
			ck_s2_ff  <= 3'h0;
			ck_s3_ff  <= 3'h0;
		end else begin
			pin_s1_ff <= io_in;
			pin_s2_ff <= pin_s1_ff;
			ded_s1_ff <= ded_in;
			ded_s2_ff <= ded_s1_ff;
			ck_s1_ff  <= {clock_pin_2, clock_pin_1, clock_pin_0};
			ck_s2_ff  <= ck_s1_ff;
			ck_s3_ff  <= ck_s2_ff;
		end
	end

	assign ck_rise = ck_s2_ff & ~ck_s3_ff;

	// ------------------------------------------------------------
	// Global routing pool and logic blocks
	// ------------------------------------------------------------
	// Feedback is taken through a flip-flop so no combinational loop can form.
	// outputs fed back
	assign global_routing_pool = {ded_s2_ff, pin_s2_ff, mc_fb_ff};

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			mc_fb_ff <= '0;
		end else begin
			mc_fb_ff <= mc_out_all;
		end
	end

	// Each block gets the pool and its own slice of configuration.
	genvar gb, gk;
	generate
		for (gb = 0; gb < plcfg_pkg::N_BLK; gb++) begin : g_blk
			plcfg_blk_if blk_if ();

			assign blk_if.global_routing_pool      = global_routing_pool;
			assign blk_if.clk_sel  = cks_ff[gb];
			assign blk_if.clk_mask = ckm_ff[gb];
			assign blk_if.clk_inv  = cki_ff[gb];
			assign blk_if.pin_rise = ck_rise;
			assign mc_out_all[gb*plcfg_pkg::N_MC +: plcfg_pkg::N_MC] = blk_if.mc_out;

			for (gk = 0; gk < plcfg_pkg::N_IN; gk++) begin : g_sel
				assign blk_if.in_sel[gk] = sel_ff[gb*plcfg_pkg::N_IN+gk];
			end
			for (gk = 0; gk < plcfg_pkg::N_MC; gk++) begin : g_mcc
				assign blk_if.pt_mask[gk] = mask_ff[gb*plcfg_pkg::N_MC+gk];
				assign blk_if.pt_inv[gk]  = inv_ff[gb*plcfg_pkg::N_MC+gk];
				assign blk_if.mc_reg[gk]  = mcc_ff[gb*plcfg_pkg::N_MC+gk][plcfg_pkg::MCC_REG_BIT];
				assign blk_if.mc_xor[gk]  = mcc_ff[gb*plcfg_pkg::N_MC+gk][plcfg_pkg::MCC_XOR_BIT];
			end

			plcfg_logic_block u_blk (
				.core_clk (core_clk),
				.rst_n    (rst_n),
				.bus      (blk_if.blk)
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Output routing pool and I/O cells
	// ------------------------------------------------------------
	// Per pin: source and enable macrocells, direction mode and driver type.
	genvar gp;
	generate
		for (gp = 0; gp < plcfg_pkg::N_PIN; gp++) begin : g_pin
			wire [4:0] src_sel = ioc_ff[gp][plcfg_pkg::IOC_SRC_LSB +: 5];
			wire [4:0] oe_sel  = ioc_ff[gp][plcfg_pkg::IOC_OE_LSB +: 5];
			wire [1:0] mode    = ioc_ff[gp][plcfg_pkg::IOC_MODE_LSB +: 2];
			wire       totem   = ioc_ff[gp][plcfg_pkg::IOC_TOTEM_BIT];
			wire       data    = mc_out_all[src_sel];
			wire       en      = (mode == plcfg_pkg::IO_OUTPUT) |
			                     ((mode == plcfg_pkg::IO_BIDIR) & mc_out_all[oe_sel]);
			assign nxt_io_drive_n[gp] = ~(totem ? en : (en & ~data));
			assign nxt_io_out[gp]     = totem & data;
			assign nxt_io_slow[gp]    = ioc_ff[gp][plcfg_pkg::IOC_SLOW_BIT];
		end
	endgenerate

	// Pin outputs are registered; nothing drives while in reset.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			io_out_ff     <= 32'h0000_0000;
			io_drive_n_ff <= 32'hFFFF_FFFF;
			io_slow_ff    <= 32'h0000_0000;
		end else begin
			io_out_ff     <= nxt_io_out;
			io_drive_n_ff <= nxt_io_drive_n;
			io_slow_ff    <= nxt_io_slow;
		end
	end

	assign io_out     = io_out_ff;
	assign io_drive_n = io_drive_n_ff;
	assign io_slow    = io_slow_ff;

endmodule

`default_nettype wire

// ### bench/plcfg_monitor.sv
// Purpose: Port-level checker of the logic fabric and its APB slave.
// Assumes: Bound to plcfg_top; one clock domain.
// Notes:   Sees only the top module's ports.
`timescale 1ns/1ns
`default_nettype none
module plcfg_monitor (
	input wire logic        core_clk,    // Core clock.
	input wire logic        rst_n,       // Synchronous reset.
	input wire logic        psel,        // APB select.
	input wire logic        penable,     // APB enable.
	input wire logic        pwrite,      // APB direction.
	input wire logic [11:0] paddr,       // APB address.
	input wire logic [31:0] prdata,      // APB read data.
	input wire logic        pready,      // APB ready.
	input wire logic        pslverr,     // APB error.
	input wire logic [31:0] io_drive_n,  // Pin drive enables.
	input wire logic [31:0] io_out,      // Pin output levels.
	input wire logic [31:0] io_slow      // Pin edge-rate selects.
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// Bus and pin checks
	// ------------------------------------------------------------
	chk_ready_access: assert property (psel && penable |-> pready) else $error("ready missing in access");
	chk_ready_idle: assert property (!(psel && penable) |-> !pready) else $error("ready outside access");
	chk_err_phase: assert property (pslverr |-> psel && penable) else $error("error outside access");
	chk_err_misalign: assert property (psel && !penable && paddr[1:0] != 2'h0 ##1 penable |-> pslverr)
		else $error("misaligned access not refused");
	chk_rd_unmapped: assert property (psel && !penable && paddr >= 12'hC00 ##1 penable |-> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
	chk_rd_hold: assert property (psel && penable |=> $stable(prdata)) else $error("read data moved after access");
	chk_reset_pins: assert property ($rose(rst_n) |-> io_drive_n == '1 && io_out == '0 && io_slow == '0)
		else $error("pins not idle after reset");
	chk_drive_status: assert property (psel && !penable && !pwrite && paddr == 12'hA08 |=> prdata == ~$past(io_drive_n))
		else $error("drive status word wrong");
	chk_slow_cause: assert property ($changed(io_slow) |-> $past(psel && penable && pwrite) ||
		$past(psel && penable && pwrite, 2) || $past(psel && penable && pwrite, 3)) else $error("slew changed unbidden");
	cp_write: cover property (psel && penable && pwrite);
	cp_error: cover property (pslverr);
	cp_float: cover property ($rose(io_drive_n[0]));
endmodule
`default_nettype wire

// ### bench/plcfg_board.sv
// Purpose: Board logic on the I/O pins, with a pull-up on every pin.
// Assumes: Board drives only the pins its enable selects.
// Notes:   A released pin rises through the pull-up.
`timescale 1ns/1ns
`default_nettype none
module plcfg_board (
	input  wire logic [31:0] io_out,     // Device output levels.
	input  wire logic [31:0] io_drive_n, // Device drive enables, low drives.
	input  wire logic [31:0] brd_val,    // Board drive levels.
	input  wire logic [31:0] brd_en,     // Board drive enables.
	output logic      [31:0] io_in       // Resolved wire levels.
);
	// Board first, then the device level wherever io_drive_n is low, else pull-up.
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			io_in[i] = brd_en[i] ? brd_val[i] : (!io_drive_n[i] ? io_out[i] : 1'b1);
		end
	end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Purpose: Self-checking bench of the logic fabric.
// Assumes: Board model resolves the pins; APB master in tasks.
// Notes:   Waits of four cycles cover the pin-to-pin latency.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top;
	logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, ck0;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, io_in, io_out, io_drive_n, io_slow, brd_val, r;
	logic e;
	int err_count, n_checks, cyc;
	plcfg_top i_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_in(io_in),
		.io_out(io_out), .io_drive_n(io_drive_n), .io_slow(io_slow), .ded_in(2'h0), .clock_pin_0(ck0),
		.clock_pin_1(1'b0), .clock_pin_2(1'b0));
	plcfg_board i_board (.io_out(io_out), .io_drive_n(io_drive_n), .brd_val(brd_val),
		.brd_en(32'h0000_0002), .io_in(io_in));
	initial begin
		core_clk = 0;
		forever #2 core_clk = ~core_clk;
	end
	// Cut a hang short.
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 5000) begin
			err_count++;
			close_out();
		end
	end
	task automatic close_out();
		if (err_count == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// One APB transfer, entered just after a rising edge.
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// Only the bench timeout ends a wait that never sees ready.
		do begin @(posedge core_clk); end while (pready !== 1'b1);
		r = prdata; e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic pin1(input logic v);
		brd_val <= {30'h0, v, 1'b0};
		repeat (4) @(posedge core_clk);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		apb(12'h800, 1'b0, 32'h0); `CHK("ioc_rst", 32'h0000_1000, r)
		`CHK("drv_rst", 32'hFFFF_FFFF, io_drive_n)
		`CHK("slow_rst", 32'h0000_0000, io_slow)
		apb(12'hC00, 1'b0, 32'h0); `CHK("err_unmapped", 1'b1, e)
		apb(12'h802, 1'b1, 32'h1); `CHK("err_misalign", 1'b1, e)
	endtask
	task automatic t_comb();
		apb(12'h000, 1'b1, 32'h21); apb(12'h400, 1'b1, 32'h1); apb(12'h800, 1'b1, 32'h1020);
		pin1(1'b1); `CHK("comb_hi", 1'b1, io_in[0])
		`CHK("comb_drv", 1'b0, io_drive_n[0])
		pin1(1'b0); `CHK("comb_lo", 1'b0, io_in[0])
	endtask
	task automatic t_od();
		apb(12'h800, 1'b1, 32'h0020); pin1(1'b1);
		`CHK("od_float", 1'b1, io_drive_n[0])
		`CHK("od_pull", 1'b1, io_in[0])
		pin1(1'b0); `CHK("od_low", 2'b00, {io_drive_n[0], io_out[0]})
		apb(12'hA08, 1'b0, 32'h0); `CHK("od_stat", 1'b1, r[0])
		apb(12'h800, 1'b1, 32'h3020); repeat (3) @(posedge core_clk);
		`CHK("slow", 2'b01, io_slow[1:0])
	endtask
	task automatic t_reg();
		apb(12'h800, 1'b1, 32'h1020); apb(12'h700, 1'b1, 32'h0); apb(12'h600, 1'b1, 32'h1);
		pin1(1'b1); `CHK("reg_hold", 1'b0, io_in[0])
		ck0 <= 1'b1; repeat (3) @(posedge core_clk); ck0 <= 1'b0; repeat (6) @(posedge core_clk);
		`CHK("reg_load", 1'b1, io_in[0])
		pin1(1'b0); `CHK("reg_keep", 1'b1, io_in[0])
		apb(12'h048, 1'b1, 32'h0); apb(12'h410, 1'b1, 32'h1); apb(12'h808, 1'b1, 32'h1024);
		repeat (4) @(posedge core_clk); `CHK("feedback", 1'b1, io_out[2])
		apb(12'h600, 1'b1, 32'h0);
		repeat (4) @(posedge core_clk);
		`CHK("feedback_lo", 1'b0, io_out[2])
	endtask
	// Block 2 clocked by its own term on pin 1; data set by the output invert; pin 4 bidirectional.
	task automatic t_term();
		apb(12'h094, 1'b1, 32'h21);
		apb(12'h728, 1'b1, 32'h2);
		apb(12'h708, 1'b1, 32'h3);
		apb(12'h620, 1'b1, 32'h3);
		apb(12'h80C, 1'b1, 32'h1028);
		repeat (2) @(posedge core_clk);
		`CHK("term_hold", 1'b1, io_out[3])
		pin1(1'b1);
		repeat (2) @(posedge core_clk);
		`CHK("term_load", 1'b0, io_out[3])
		apb(12'h620, 1'b1, 32'h1);
		pin1(1'b0);
		`CHK("term_keep", 1'b0, io_out[3])
		pin1(1'b1);
		repeat (2) @(posedge core_clk);
		`CHK("term_reload", 1'b1, io_out[3])
		apb(12'h810, 1'b1, 32'h1048);
		repeat (2) @(posedge core_clk);
		`CHK("bidir_on", 2'b01, {io_drive_n[4], io_out[4]})
		pin1(1'b0);
		`CHK("bidir_off", 1'b1, io_drive_n[4])
	endtask
	initial begin
		{psel, penable, pwrite, ck0, rst_n} = '0;
		{paddr, pwdata, brd_val} = '0;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_comb();
		t_od();
		t_reg();
		t_term();
		close_out();
	end
endmodule
bind plcfg_top plcfg_monitor i_mon (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.io_drive_n(io_drive_n), .io_out(io_out), .io_slow(io_slow));
`default_nettype wire
